// ---- rtl/lcg_map.vh ----
// Register map, field positions, reset values and counts for the LPC clock
// control block. Included by the design files; holds definitions only.
`ifndef LCG_MAP_VH
`define LCG_MAP_VH

// Register byte offsets on the AXI4-Lite bus
`define LCG_CLOCK_CONFIG_OFS 4'h0
`define LCG_INTERRUPT_CONFIG_OFS 4'h4
`define LCG_STATUS_OFS 4'h8

// lpc_clock_config fields
`define LCG_CLK0_EN_BIT 0
`define LCG_CLK1_EN_BIT 1
`define LCG_CLOCK_RUN_EN_BIT 2
`define LCG_LOOPBACK_SEL_BIT 3
`define LCG_CLK1_STATUS_BIT 4

// interrupt_config fields
`define LCG_SERIAL_IRQ_EN_BIT 0

// status fields
`define LCG_STAT_CLK_RUNNING_BIT 0
`define LCG_STAT_STATE_LSB 1
`define LCG_STAT_LINE_DRIVEN_BIT 3
`define LCG_STAT_LINE_LEVEL_BIT 4

// Reset values
`define LCG_CLK0_EN_RESET 1'b1
`define LCG_CLOCK_RUN_EN_RESET 1'b0
`define LCG_SERIAL_IRQ_EN_RESET 1'b1

// LPC clocks a peripheral has to claim the clock after release
`define LCG_CLOCK_RUN_WAIT 3'h4

// AXI responses
`define LCG_RESP_OKAY 2'b00
`define LCG_RESP_SLVERR 2'b10

`endif

// ---- rtl/lcg_clock_gate.v ----
// Glitch-free gate for one LPC clock output, rebuilt from the sampled
// source clock. Assumes src is already synchronised to clk.
module lcg_clock_gate (
  input wire clk,
  input wire rst_n,
  input wire src,
  input wire en,
  output reg gated
);

  reg en_held;

  // Enable only moves while the source is low, so a pulse is whole or absent
  always @(posedge clk) begin
    if (!rst_n) begin
      en_held <= 1'b0;
      gated <= 1'b0;
    end else begin
      if (!src)
        en_held <= en; // see R11
      gated <= src & en_held; // see R4
    end
  end

endmodule

// ---- rtl/lcg_top.v ----
// LPC clock loopback, output gating, clock-run and serial IRQ enable,
// with an AXI4-Lite register slave.
// Assumes MCLK at 250 MHz; LPC source clock, straps and the clock-run
// line arrive from outside MCLK and are synchronised here.
//
// Contract
// R1 - Strap 0: loop first clock back at pad
// R2 - Strap 1: board loopback, second clock disabled
// R3 - Straps readable in configuration bits
// R4 - Each clock output follows its enable bit
// R5 - Clock-run off after reset until enabled
// R6 - Software enables clock-run after peripherals initialised
// R7 - Serial IRQ enable 0 disables IRQ frames
// R8 - Release clock-run only when idle and quiet
// R9 - Stop clock unless claimed within 4 clocks
// R10 - Claimed line restarts clock, device drives low
// R11 - Clock enable switches only while source low
`include "lcg_map.vh"

module lcg_top (
  input wire MCLK,
  input wire RST_N,
  input wire LPC_SRC_CLK,
  input wire LOOPBACK_SELECT_STRAP,
  input wire SECOND_CLOCK_STRAP_ENABLE,
  input wire LPC_CYCLES_PENDING,
  input wire SERIAL_IRQ_QUIET,
  input wire CLOCK_RUN_LINE_N_IN,
  output reg CLOCK_RUN_LINE_N_OUT,
  output reg CLOCK_RUN_LINE_N_OE,
  output wire LPC_CLOCK_OUT0,
  output wire LPC_CLOCK_OUT1,
  output reg PAD_LOOPBACK_EN,
  output reg SERIAL_IRQ_ENABLE,
  input wire [3:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [3:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);

  // Clock-run states
  localparam ST_OFF = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_RELEASE = 2'd2;
  localparam ST_STOPPED = 2'd3;

  // True when the word offset names a register of this block
  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `LCG_CLOCK_CONFIG_OFS) || (addr == `LCG_INTERRUPT_CONFIG_OFS) ||
        (addr == `LCG_STATUS_OFS);
    end
  endfunction

  // Pin synchronisers; first stages read only by second stages
  reg src_s1, src_s2, src_d;
  reg run_s1, run_s2;
  reg lsel_s1, lsel_s2;
  reg c1_s1, c1_s2;

  reg strap_taken;
  reg [1:0] strap_fill;
  reg loopback_select;
  reg second_clock_enable_status;
  reg clk0_en;
  reg clk1_en;
  reg clock_run_enable;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] wait_cnt;
  reg [1:0] settle_cnt;
  reg clock_allowed;
  reg aw_held, w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire src_rise;
  wire strap_ready;
  wire line_claimed;
  wire idle;
  wire gate0_en;
  wire gate1_en;
  wire wr_go;
  wire [31:0] cfg_word;
  wire [31:0] irq_word;
  wire [31:0] stat_word;

  // Two flip-flops on every outside level before use
  always @(posedge MCLK) begin
    if (!RST_N) begin
      src_s1 <= 1'b0;
      src_s2 <= 1'b0;
      src_d <= 1'b0;
      run_s1 <= 1'b1;
      run_s2 <= 1'b1;
      lsel_s1 <= 1'b0;
      lsel_s2 <= 1'b0;
      c1_s1 <= 1'b0;
      c1_s2 <= 1'b0;
    end else begin
      src_s1 <= LPC_SRC_CLK;
      src_s2 <= src_s1;
      src_d <= src_s2;
      run_s1 <= CLOCK_RUN_LINE_N_IN;
      run_s2 <= run_s1;
      lsel_s1 <= LOOPBACK_SELECT_STRAP;
      lsel_s2 <= lsel_s1;
      c1_s1 <= SECOND_CLOCK_STRAP_ENABLE;
      c1_s2 <= c1_s1;
    end
  end

  // Our own low drive lingers in the synchroniser for two edges after release
  assign src_rise = src_s2 & ~src_d;
  assign line_claimed = ~run_s2 & settle_cnt[1];
  assign idle = ~LPC_CYCLES_PENDING & SERIAL_IRQ_QUIET;
  assign strap_ready = ~strap_taken & (strap_fill == 2'h3);

  // Straps are caught once, after the synchronisers have filled
  always @(posedge MCLK) begin
    if (!RST_N) begin
      strap_taken <= 1'b0;
      strap_fill <= 2'h0;
      loopback_select <= 1'b0;
      second_clock_enable_status <= 1'b0;
      PAD_LOOPBACK_EN <= 1'b1;
    end else begin
      // Second stages still hold reset values for two edges after release
      if (strap_fill != 2'h3)
        strap_fill <= strap_fill + 2'h1;
      if (strap_ready) begin
        strap_taken <= 1'b1;
        loopback_select <= lsel_s2; // see R3
        // Board loopback returns clock 0 on pin 1, so pin 1 may never drive
        second_clock_enable_status <= c1_s2 & ~lsel_s2; // see R2
        PAD_LOOPBACK_EN <= ~lsel_s2; // see R1
      end
    end
  end

  // Clock-run state machine
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (clock_run_enable)
          next_state = ST_RUN; // see R5
      end
      ST_RUN: begin
        if (!clock_run_enable)
          next_state = ST_OFF;
        else if (idle && src_rise)
          next_state = ST_RELEASE; // see R8
      end
      ST_RELEASE: begin
        if (!clock_run_enable || line_claimed || !idle)
          next_state = ST_RUN; // see R10
        else if (src_rise && wait_cnt == `LCG_CLOCK_RUN_WAIT - 3'h1)
          next_state = ST_STOPPED; // see R9
      end
      ST_STOPPED: begin
        if (!clock_run_enable || line_claimed || !idle)
          next_state = ST_RUN; // see R10
      end
      default: next_state = ST_OFF;
    endcase
  end

  // State, wait count and the clock-run pin
  always @(posedge MCLK) begin
    if (!RST_N) begin
      state <= ST_OFF;
      wait_cnt <= 3'h0;
      settle_cnt <= 2'h0;
      clock_allowed <= 1'b1;
      CLOCK_RUN_LINE_N_OUT <= 1'b1;
      CLOCK_RUN_LINE_N_OE <= 1'b0;
    end else begin
      state <= next_state;
      // The rise that releases the line is not one of the four
      if (next_state != ST_RELEASE)
        wait_cnt <= 3'h0;
      else if (state == ST_RELEASE && src_rise)
        wait_cnt <= wait_cnt + 3'h1; // see R9
      if (state == ST_RUN || state == ST_OFF)
        settle_cnt <= 2'h0;
      else if (settle_cnt != 2'h3)
        settle_cnt <= settle_cnt + 2'h1; // see R10
      clock_allowed <= (next_state != ST_STOPPED);
      // Driven low in run, released otherwise; the pull-up gives the high
      CLOCK_RUN_LINE_N_OUT <= 1'b0;
      CLOCK_RUN_LINE_N_OE <= (next_state == ST_RUN); // see R10
    end
  end

  assign gate0_en = clk0_en & clock_allowed;
  assign gate1_en = clk1_en & ~loopback_select & clock_allowed; // see R2

  // One gate per clock output
  lcg_clock_gate u_gate0 (
    .clk(MCLK),
    .rst_n(RST_N),
    .src(src_s2),
    .en(gate0_en),
    .gated(LPC_CLOCK_OUT0)
  );

  lcg_clock_gate u_gate1 (
    .clk(MCLK),
    .rst_n(RST_N),
    .src(src_s2),
    .en(gate1_en),
    .gated(LPC_CLOCK_OUT1)
  );

  // Register read images
  assign cfg_word = {27'h0, second_clock_enable_status, loopback_select, clock_run_enable,
    clk1_en, clk0_en};
  assign irq_word = {31'h0, SERIAL_IRQ_ENABLE};
  assign stat_word = {27'h0, run_s2, CLOCK_RUN_LINE_N_OE, state, clock_allowed};

  assign wr_go = aw_held & w_held & ~S_AXI_BVALID;

  // Write address and data may arrive in either order
  always @(posedge MCLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `LCG_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= ~aw_held & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY <= ~w_held & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped({aw_addr[3:2], 2'b00}) ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Writable control bits; only byte lane 0 carries fields
  always @(posedge MCLK) begin
    if (!RST_N) begin
      clk0_en <= `LCG_CLK0_EN_RESET;
      clk1_en <= 1'b0;
      clock_run_enable <= `LCG_CLOCK_RUN_EN_RESET; // see R5
      SERIAL_IRQ_ENABLE <= `LCG_SERIAL_IRQ_EN_RESET;
    end else begin
      // Second clock starts as its strap says, once straps are caught
      if (strap_ready)
        clk1_en <= c1_s2 & ~lsel_s2;
      if (wr_go && w_strb[0]) begin
        if ({aw_addr[3:2], 2'b00} == `LCG_CLOCK_CONFIG_OFS) begin
          clk0_en <= w_data[`LCG_CLK0_EN_BIT]; // see R4
          clk1_en <= w_data[`LCG_CLK1_EN_BIT]; // see R4
          clock_run_enable <= w_data[`LCG_CLOCK_RUN_EN_BIT]; // see R5
        end
        if ({aw_addr[3:2], 2'b00} == `LCG_INTERRUPT_CONFIG_OFS)
          SERIAL_IRQ_ENABLE <= w_data[`LCG_SERIAL_IRQ_EN_BIT]; // see R7
      end
    end
  end

  // Read channel, one read outstanding; answer one cycle after the take
  always @(posedge MCLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `LCG_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `LCG_RESP_OKAY;
        case ({S_AXI_ARADDR[3:2], 2'b00})
          `LCG_CLOCK_CONFIG_OFS: S_AXI_RDATA <= cfg_word; // see R3
          `LCG_INTERRUPT_CONFIG_OFS: S_AXI_RDATA <= irq_word;
          `LCG_STATUS_OFS: S_AXI_RDATA <= stat_word;
          default: begin
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `LCG_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

// ---- tb/lcg_sva.sv ----
// Port assertions for the LPC clock control block.
// Bound to lcg_top; sees its ports only.
module lcg_sva (
  input wire MCLK,
  input wire RST_N,
  input wire LOOPBACK_SELECT_STRAP,
  input wire LPC_CYCLES_PENDING,
  input wire SERIAL_IRQ_QUIET,
  input wire CLOCK_RUN_LINE_N_IN,
  input wire CLOCK_RUN_LINE_N_OUT,
  input wire CLOCK_RUN_LINE_N_OE,
  input wire LPC_CLOCK_OUT0,
  input wire LPC_CLOCK_OUT1,
  input wire PAD_LOOPBACK_EN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  reg armed;
  reg [7:0] rel_cnt;
  // Unclaimed cycles since a release; saturates so a stop stays watched
  always @(posedge MCLK) begin
    if (!RST_N || CLOCK_RUN_LINE_N_OE || !CLOCK_RUN_LINE_N_IN) begin
      armed <= 1'b0;
      rel_cnt <= 8'h00;
    end else if (armed || $fell(CLOCK_RUN_LINE_N_OE)) begin
      armed <= 1'b1;
      rel_cnt <= rel_cnt + {7'h00, rel_cnt != 8'hff};
    end
  end
  sequence release_s;
    $fell(CLOCK_RUN_LINE_N_OE);
  endsequence
  sequence claim_s;
    $fell(CLOCK_RUN_LINE_N_IN);
  endsequence
  quiet_boot_a:
    assert property ($rose(RST_N) |-> !CLOCK_RUN_LINE_N_OE [*8])
    else $error("line driven after reset");
  strap_mirror_a:
    assert property ($rose(RST_N) |-> ##[1:60] PAD_LOOPBACK_EN == !LOOPBACK_SELECT_STRAP)
    else $error("pad loopback differs from strap");
  board_clk1_a:
    assert property (!PAD_LOOPBACK_EN [*8] |-> !LPC_CLOCK_OUT1)
    else $error("second clock runs in board loopback");
  idle_release_a:
    assert property (release_s |-> !$past(LPC_CYCLES_PENDING) && $past(SERIAL_IRQ_QUIET))
    else $error("release while busy");
  claim_back_a:
    assert property (release_s ##[1:300] claim_s |-> ##[1:5] CLOCK_RUN_LINE_N_OE)
    else $error("claim not answered");
  drive_low_a:
    assert property (CLOCK_RUN_LINE_N_OE |-> !CLOCK_RUN_LINE_N_OUT)
    else $error("line driven high");
  clock_stop_a:
    assert property (rel_cnt >= 8'he6 |-> !LPC_CLOCK_OUT0 && !LPC_CLOCK_OUT1)
    else $error("clock not stopped");
  no_runt_a:
    assert property ($rose(LPC_CLOCK_OUT0) |-> LPC_CLOCK_OUT0 [*8])
    else $error("short clock pulse");
endmodule

bind lcg_top lcg_sva lcg_sva_inst (.MCLK(MCLK), .RST_N(RST_N),
  .LOOPBACK_SELECT_STRAP(LOOPBACK_SELECT_STRAP), .LPC_CYCLES_PENDING(LPC_CYCLES_PENDING),
  .SERIAL_IRQ_QUIET(SERIAL_IRQ_QUIET), .CLOCK_RUN_LINE_N_IN(CLOCK_RUN_LINE_N_IN),
  .CLOCK_RUN_LINE_N_OUT(CLOCK_RUN_LINE_N_OUT), .CLOCK_RUN_LINE_N_OE(CLOCK_RUN_LINE_N_OE),
  .LPC_CLOCK_OUT0(LPC_CLOCK_OUT0), .LPC_CLOCK_OUT1(LPC_CLOCK_OUT1),
  .PAD_LOOPBACK_EN(PAD_LOOPBACK_EN));

// ---- tb/lcg_periph.sv ----
// Peripheral on the clock-run line.
// Sees the gated LPC clock and the resolved line level.
module lcg_periph (
  input wire lpc_clk,
  input wire line_n,
  input wire need,
  input wire [2:0] lag,
  output reg pull
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pull = 1'b0;
  // Claim lag clocks after a release; lag 0 wakes a stopped clock
  always begin
    wait (need && line_n);
    repeat (lag) @(posedge lpc_clk);
    pull = 1'b1;
    repeat (2) @(posedge lpc_clk);
    pull = 1'b0;
  end
endmodule

// ---- tb/lcg_top_tb.sv ----
// Bench for the LPC clock control block over AXI4-Lite.
// Needs lcg_top, lcg_periph and the bound checker.
module lcg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg mclk = 1'b0, src = 1'b0, rst_n = 1'b0, sel = 1'b0, s1 = 1'b1;
  reg pend = 1'b1, quiet = 1'b0, need = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  reg [2:0] lag = 3'h3;
  reg [3:0] awa = 4'h0, ara = 4'h0;
  reg [31:0] wd = 32'h0;
  wire awr, wrd, bv, arr, rv, oe, out, clk0, clk1, pad, sirq, pull;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  // Open-drain line with pull-up
  wire line_n = !((oe && !out) || pull);
  int fails = 0, checks_done = 0, cyc = 0, c0, c1;
  lcg_top lcg_top_inst (.MCLK(mclk), .RST_N(rst_n), .LPC_SRC_CLK(src),
    .LOOPBACK_SELECT_STRAP(sel), .SECOND_CLOCK_STRAP_ENABLE(s1), .LPC_CYCLES_PENDING(pend),
    .SERIAL_IRQ_QUIET(quiet), .CLOCK_RUN_LINE_N_IN(line_n), .CLOCK_RUN_LINE_N_OUT(out),
    .CLOCK_RUN_LINE_N_OE(oe), .LPC_CLOCK_OUT0(clk0), .LPC_CLOCK_OUT1(clk1),
    .PAD_LOOPBACK_EN(pad), .SERIAL_IRQ_ENABLE(sirq), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));
  lcg_periph lcg_periph_inst (.lpc_clk(clk0), .line_n(line_n), .need(need), .lag(lag),
    .pull(pull));
  // 250 MHz system clock
  always #2 mclk = ~mclk;
  // Free link source, off the mclk edges
  initial begin
    #0.7;
    forever #80 src = ~src;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cut a hang short; tests need about 3400 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write; address and data released as each is taken
  task automatic axw(input [3:0] a, input [31:0] d, input [1:0] er);
    bit ta, tw;
    ta = 0;
    tw = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (awr && !ta) begin
        ta = 1;
        awv <= 1'b0;
      end
      if (wrd && !tw) begin
        tw = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge mclk); while (!bv);
    chk("bresp", br, er);
  endtask
  task automatic axr(input [3:0] a, input [31:0] e, input [1:0] er);
    ara <= a;
    arv <= 1'b1;
    do @(posedge mclk); while (!arr);
    arv <= 1'b0;
    do @(posedge mclk); while (!rv);
    chk("rdata", rdat, e);
    chk("rresp", rr, er);
  endtask
  // Count rising edges of both clock outputs
  task automatic rises(input int n);
    bit p0, p1;
    c0 = 0;
    c1 = 0;
    repeat (n) begin
      p0 = clk0;
      p1 = clk1;
      @(posedge mclk);
      c0 += int'(clk0 && !p0);
      c1 += int'(clk1 && !p1);
    end
  endtask
  // Straps are set with reset and held after it
  task automatic boot(input bit b_sel, input bit b_s1);
    rst_n <= 1'b0;
    sel <= b_sel;
    s1 <= b_s1;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (100) @(posedge mclk);
  endtask
  initial begin
    boot(1'b0, 1'b1);
    axr(4'h0, 32'h13, 2'b00);
    chk("pad", pad, 1);
    rises(400);
    chk("clk1 on", c1 != 0, 1);
    axw(4'h0, 32'h1, 2'b00);
    axr(4'h0, 32'h11, 2'b00);
    rises(400);
    chk("clk0 on", c0 != 0, 1);
    chk("clk1 off", c1, 0);
    axw(4'hc, 32'h1, 2'b10);
    axr(4'hc, 32'h0, 2'b10);
    axw(4'h4, 32'h0, 2'b00);
    chk("sirq", sirq, 0);
    axr(4'h4, 32'h0, 2'b00);
    $display("test pad loopback done");
    pend <= 1'b0;
    quiet <= 1'b1;
    repeat (200) @(posedge mclk);
    chk("oe off", oe, 0);
    need <= 1'b1;
    axw(4'h0, 32'h5, 2'b00);
    rises(600);
    chk("claimed", c0 >= 14, 1);
    pend <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("oe run", oe, 1);
    pend <= 1'b0;
    need <= 1'b0;
    repeat (600) @(posedge mclk);
    rises(200);
    chk("stopped", c0, 0);
    axr(4'h8, 32'h16, 2'b00);
    lag <= 3'h0;
    need <= 1'b1;
    rises(300);
    chk("restart", c0 != 0, 1);
    $display("test clock run done");
    boot(1'b1, 1'b0);
    axr(4'h0, 32'h09, 2'b00);
    chk("pad", pad, 0);
    axw(4'h0, 32'h3, 2'b00);
    rises(400);
    chk("clk1 off", c1, 0);
    chk("clk0 on", c0 != 0, 1);
    $display("test board loopback done");
    print_verdict;
  end
endmodule
